// [dcad_top.sv]
/*
 * command/address receiver and row, bank, column decoder, with a request fifo.
 * assumes the controller drives the link and its clock, which is sampled by our clock.
 */
// Functional notes
// - eight banks, selected by three bank select bits in each command
// - command, address and bank all arrive on one six-bit bus
// - each command spans two link cycles, sampled on the rising link edge
// - data lines carry two bits per cycle, one each half cycle
// - one access is a 16n word serialised into eight link cycles
// - bursts start at the selected column and run the programmed length
// - activate opens a row in a bank from its captured address bits
// - column commands give the bank and starting column of the burst
// - the four low column bits are not sent and read as zero
// - rows breaking that restriction are undefined; only flagged, never relied on
// - inputs are sampled where the true clock rises
// - chip select and clock enable are part of the command code
`timescale 1ns/1ps
`include "dcad_cfg.svh"

/* ****************************************************************** */
/* request fifo                                                       */
/* ****************************************************************** */
module dcad_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `DCAD_FIFO_DEPTH
) (
	input  wire logic             clock,     // system clock
	input  wire logic             rst_b,     // sync reset, low
	input  wire logic [WIDTH-1:0] inData,    // write data
	input  wire logic             inValid,   // write request
	output logic                  inReady,   // not full
	output logic      [WIDTH-1:0] outData,   // head word
	output logic                  outValid,  // not empty
	input  wire logic             outReady   // drain
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// honest full and empty from the occupancy count
	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// storage written only on push
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

/* ****************************************************************** */
/* decoder top                                                        */
/* ****************************************************************** */
module dcad_top #(
	parameter int ROW_BITS = 17  // row bits used at this density
) (
	input  wire logic                       clock,          // system clock, 50 MHz
	input  wire logic                       rst_b,          // sync reset, low
	input  wire logic                       clockTrue,      // link clock from controller
	input  wire logic                       clockEnable,    // link clock enable pin
	input  wire logic                       chipSelect,     // chip select pin
	input  wire logic [`DCAD_CA_W-1:0]      cmdAddrBus,     // command/address pins
	output dcad_pkg::dcad_req_t             reqOut,         // decoded burst request
	output logic                            reqValid,       // request present
	input  wire logic                       reqReady,       // consumer takes request
	output logic                            cmdDropped,     // pulse: fifo full, lost
	output logic                            cmdNoRow        // pulse: column cmd, bank closed
);
	typedef enum logic [1:0] {
		DCAD_IDLE,
		DCAD_ACT_TWO,
		DCAD_COL_TWO
	} dcad_state_t;

	logic [`DCAD_CA_W-1:0] caSync1_q, caSync2_q;
	logic [2:0]            ckSync_q;
	logic                  csSync1_q, csSync2_q, ckeSync1_q, ckeSync2_q;
	logic                  linkRise;
	dcad_state_t           state_q;
	logic [`DCAD_CA_W-1:0] first_q;
	logic                  firstCs_q;
	logic [`DCAD_ROW_W-1:0]  openRow_q [8];
	logic [7:0]              bankOpen_q;
	dcad_pkg::dcad_req_t   req_d;
	logic                  push_q;
	dcad_pkg::dcad_req_t   pushData_q;
	logic                  fifoReady;
	dcad_pkg::dcad_req_t   fifoData;
	logic                  fifoValid;
	logic [`DCAD_BANK_W-1:0] colBank;

	// two flops on every pin; third clock stage only feeds the edge detector
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			caSync1_q  <= '0;
			caSync2_q  <= '0;
			ckSync_q   <= 3'h0;
			csSync1_q  <= 1'b0;
			csSync2_q  <= 1'b0;
			ckeSync1_q <= 1'b0;
			ckeSync2_q <= 1'b0;
		end else begin
			caSync1_q  <= cmdAddrBus;
			caSync2_q  <= caSync1_q;
			ckSync_q   <= {ckSync_q[1:0], clockTrue};
			csSync1_q  <= chipSelect;
			csSync2_q  <= csSync1_q;
			ckeSync1_q <= clockEnable;
			ckeSync2_q <= ckeSync1_q;
		end
	end

	// rising true clock seen after the sync stages; data pins lag by the same two flops
	assign linkRise = ckSync_q[1] && !ckSync_q[2] && ckeSync2_q;

	// two-cycle command framing
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q   <= DCAD_IDLE;
			first_q   <= '0;
			firstCs_q <= 1'b0;
		end else if (linkRise) begin
			case (state_q)
				DCAD_IDLE: begin
					// chip select high with our codes opens a command
					if (csSync2_q && caSync2_q[1:0] == `DCAD_OP_ACT1) begin
						state_q <= DCAD_ACT_TWO;
					end else if (csSync2_q && (caSync2_q[2:0] == `DCAD_CMD_RD ||
						caSync2_q[2:0] == `DCAD_CMD_WR || caSync2_q[2:0] == `DCAD_CMD_MWR)) begin
						state_q <= DCAD_COL_TWO;
					end
					first_q   <= caSync2_q;
					firstCs_q <= csSync2_q;
				end
				default: begin
					state_q <= DCAD_IDLE;
				end
			endcase
		end
	end

	// bank of a column command rides the upper bits of its first cycle
	assign colBank = first_q[5:3];

	// activate: bank from the second cycle, row from both cycles, unused high row bits ignored
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bankOpen_q <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				openRow_q[i] <= '0;
			end
		end else if (linkRise && state_q == DCAD_ACT_TWO) begin
			bankOpen_q[caSync2_q[2:0]] <= 1'b1;
			openRow_q[caSync2_q[2:0]]  <= `DCAD_ROW_W'({first_q[5:2], caSync2_q[5:3], 12'h000}
				& ((`DCAD_ROW_W'(1) << ROW_BITS) - 1'b1));
		end
	end

	// burst request: column low bits forced zero, open row joined
	always_comb begin
		req_d        = '0;
		req_d.bank   = colBank;
		req_d.row    = openRow_q[colBank];
		req_d.col    = {caSync2_q[5:0], 2'h0, 2'h0};
		req_d.kind   = (first_q[2:0] == `DCAD_CMD_RD)  ? dcad_pkg::DCAD_KIND_READ :
		               (first_q[2:0] == `DCAD_CMD_MWR) ? dcad_pkg::DCAD_KIND_MASK_WRITE :
		                                                 dcad_pkg::DCAD_KIND_WRITE;
		// flag only: a row breaking the non-binary rule is never relied on
		req_d.rowBad = openRow_q[colBank][ROW_BITS-1] &&
			openRow_q[colBank][ROW_BITS-2];
	end

	// one push per completed column command on an open bank; the fifo takes the burst unless full
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			push_q     <= 1'b0;
			pushData_q <= '0;
			cmdDropped <= 1'b0;
			cmdNoRow   <= 1'b0;
		end else begin
			push_q     <= linkRise && state_q == DCAD_COL_TWO && bankOpen_q[colBank]
				&& firstCs_q;
			pushData_q <= req_d;
			cmdNoRow   <= linkRise && state_q == DCAD_COL_TWO && !bankOpen_q[colBank];
			cmdDropped <= push_q && !fifoReady;
		end
	end

	// eight-beat serialisation of each request is left to the data path
	dcad_fifo #(
		.WIDTH ($bits(dcad_pkg::dcad_req_t)),
		.DEPTH (`DCAD_FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.rst_b    (rst_b),
		.inData   (pushData_q),
		.inValid  (push_q),
		.inReady  (fifoReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (!reqValid || reqReady)  // pop exactly when the output stage loads
	);

	// output register stage keeps the top outputs straight from flops
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			reqOut   <= '0;
			reqValid <= 1'b0;
		end else if (!reqValid || reqReady) begin
			reqValid <= fifoValid;
			reqOut   <= fifoData;
		end
	end
endmodule

// [dcad_cfg.svh]
/*
 * constants of the command/address decoder: bus widths, command codes, row and column limits.
 * assumes nothing; included by the package and the design.
 */
`ifndef DCAD_CFG_SVH
`define DCAD_CFG_SVH
`define DCAD_CA_W         6
`define DCAD_BANK_W       3
`define DCAD_ROW_W        19
`define DCAD_COL_W        10
`define DCAD_CLK_MHZ      50
`define DCAD_LINK_NS      160
// first-cycle codes on the command/address bus, with chip select high
// column codes fill the low three bits so the upper three stay free for the bank
`define DCAD_OP_ACT1      2'h1
`define DCAD_CMD_WR       3'h4
`define DCAD_CMD_MWR      3'h6
`define DCAD_CMD_RD       3'h2
`define DCAD_CMD_ACT2_LO  2'h3
`define DCAD_BURST_BEATS  4'h8
`define DCAD_FIFO_DEPTH   8
`endif

// [dcad_pkg.sv]
/*
 * types of the command/address decoder.
 * assumes dcad_cfg.svh sits in the include path.
 */
`include "dcad_cfg.svh"
package dcad_pkg;
	typedef enum logic [1:0] {
		DCAD_KIND_READ,
		DCAD_KIND_WRITE,
		DCAD_KIND_MASK_WRITE
	} dcad_kind_t;

	// one decoded burst request
	typedef struct packed {
		dcad_kind_t                kind;
		logic [`DCAD_BANK_W-1:0]   bank;
		logic [`DCAD_ROW_W-1:0]    row;
		logic [`DCAD_COL_W-1:0]    col;
		logic                      rowBad;
	} dcad_req_t;
endpackage

// [dcad_checker.sv]
/*
 * assertions on the decoder top: request contents, hold while waiting, pulse shapes, reset.
 * assumes it is bound to dcad_top and that all watched ports sit in the one clock domain.
 */
`timescale 1ns/1ps
/* ************************************************************ */
/* checker                                                      */
/* ************************************************************ */
module dcad_checker #(
	parameter int ROW_BITS = 17  // row bits used at this density
) (
	input wire logic                clock,       // system clock
	input wire logic                rst_b,       // sync reset, low
	input dcad_pkg::dcad_req_t      reqOut,      // decoded request
	input wire logic                reqValid,    // request present
	input wire logic                reqReady,    // consumer takes
	input wire logic                cmdDropped,  // fifo full pulse
	input wire logic                cmdNoRow     // closed bank pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// a waiting request must not move under the consumer
	property p_hold; reqValid && !reqReady |=> reqValid && $stable(reqOut); endproperty
	a_hold: assert property (p_hold) else $error("request changed while waiting");
	property p_col; reqValid |-> reqOut.col[1:0] == 2'h0; endproperty
	a_col: assert property (p_col) else $error("low column bits not zero");
	property p_high; reqValid |-> (reqOut.row >> ROW_BITS) == 0; endproperty
	a_high: assert property (p_high) else $error("unused row bits set");
	property p_low; reqValid |-> reqOut.row[11:0] == 12'h000; endproperty
	a_low: assert property (p_low) else $error("row low bits not zero");
	property p_bad; reqValid |-> reqOut.rowBad == (reqOut.row[ROW_BITS-1] && reqOut.row[ROW_BITS-2]); endproperty
	a_bad: assert property (p_bad) else $error("row flag wrong");
	property p_kind; reqValid |-> reqOut.kind != 2'h3; endproperty
	a_kind: assert property (p_kind) else $error("unknown request kind");
	// commands are two link cycles apart, so pulses can never sit close together
	property p_drop; cmdDropped |=> !cmdDropped [*8]; endproperty
	a_drop: assert property (p_drop) else $error("drop pulse too long");
	property p_norow; cmdNoRow |=> !cmdNoRow [*8]; endproperty
	a_norow: assert property (p_norow) else $error("closed bank pulse too long");
	property p_excl; !(cmdDropped && cmdNoRow); endproperty
	a_excl: assert property (p_excl) else $error("both refusal pulses at once");
	property p_rst; @(posedge clock) disable iff (1'b0) !rst_b |=> !reqValid && !cmdDropped && !cmdNoRow; endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	c_take: cover property (reqValid && reqReady);
	c_drop: cover property (cmdDropped);
	c_norow: cover property (cmdNoRow);
	c_bad: cover property (reqValid && reqOut.rowBad);
endmodule

bind dcad_top dcad_checker #(.ROW_BITS(ROW_BITS)) u_dcad_checker (.clock(clock), .rst_b(rst_b),
	.reqOut(reqOut), .reqValid(reqValid), .reqReady(reqReady), .cmdDropped(cmdDropped),
	.cmdNoRow(cmdNoRow));

// [dcad_ctrl_model.sv]
/*
 * controller model: sends two-cycle commands with a link clock that stands still between them.
 * assumes the bench calls send only after reset has been released.
 */
`timescale 1ns/1ps
`include "dcad_cfg.svh"
/* ************************************************************ */
/* controller                                                   */
/* ************************************************************ */
module dcad_ctrl_model (
	output logic                 clockTrue,    // link clock
	output logic                 clockEnable,  // link enable
	output logic                 chipSelect,   // chip select
	output logic [`DCAD_CA_W-1:0] cmdAddrBus   // command/address pins
);
	// idle bus shows the inverse of a pattern so a stale value is never read as valid
	initial begin
		clockTrue = 1'b0;
		clockEnable = 1'b1;
		chipSelect = 1'b0;
		cmdAddrBus = 6'h2A;
	end
	// data changes only while the link clock is low, half a link cycle from the sampling rise
	task automatic send(input logic [5:0] c1, input logic [5:0] c2, input logic ce);
		#3;
		clockEnable = ce;
		chipSelect = 1'b1;
		// unused row bits seventeen and eighteen driven high, as the bench density needs
		cmdAddrBus = (c1[1:0] == `DCAD_OP_ACT1) ? (c1 | 6'h30) : c1;
		#80 clockTrue = 1'b1;
		#80 clockTrue = 1'b0;
		chipSelect = 1'b0;
		cmdAddrBus = c2;
		#80 clockTrue = 1'b1;
		#80 clockTrue = 1'b0;
		cmdAddrBus = ~c2;
		clockEnable = 1'b1;
		// odd tail keeps every pin change off the system clock's rising edge
		#7;
	endtask
endmodule

// [dcad_tb.sv]
/*
 * bench of the decoder top: closed bank, activate and column commands, enable low, overflow.
 * assumes the controller model drives the link; the bench drives reset and the consumer.
 */
`timescale 1ns/1ps
`include "dcad_cfg.svh"
/* ************************************************************ */
/* bench                                                        */
/* ************************************************************ */
module tb;
	localparam int RB = 17;
	logic                  clock = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  reqReady = 1'b0;
	logic                  clockTrue, clockEnable, chipSelect, reqValid, cmdDropped, cmdNoRow;
	logic [`DCAD_CA_W-1:0] cmdAddrBus;
	dcad_pkg::dcad_req_t   reqOut;
	int                    n_errors = 0, comparisons = 0, cyc = 0, nDrop = 0, nNoRow = 0;
	always #10 clock = ~clock;
	dcad_ctrl_model u_dcad_ctrl_model (.clockTrue(clockTrue), .clockEnable(clockEnable),
		.chipSelect(chipSelect), .cmdAddrBus(cmdAddrBus));
	dcad_top #(.ROW_BITS(RB)) u_dcad_top (.clock(clock), .rst_b(rst_b), .clockTrue(clockTrue),
		.clockEnable(clockEnable), .chipSelect(chipSelect), .cmdAddrBus(cmdAddrBus),
		.reqOut(reqOut), .reqValid(reqValid), .reqReady(reqReady), .cmdDropped(cmdDropped),
		.cmdNoRow(cmdNoRow));
	// pulse counters and the hang limit, well above the four hundred or so cycles needed
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (rst_b && cmdDropped === 1'b1) nDrop <= nDrop + 1;
		if (rst_b && cmdNoRow === 1'b1) nNoRow <= nNoRow + 1;
		if (cyc == 8000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_cnt(input int got, input int exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t count %0d, expected %0d", $time, got, exp);
		end
	endtask
	// waits for a request, compares it, then takes it with a one-cycle ready
	task automatic chk_req(input dcad_pkg::dcad_req_t e);
		int i;
		@(posedge clock);
		for (i = 0; i < 300 && reqValid !== 1'b1; i++) @(posedge clock);
		comparisons++;
		if (reqValid !== 1'b1 || reqOut !== e) begin
			n_errors++;
			$display("Error %0t request %h, expected %h", $time, reqOut, e);
		end
		reqReady <= 1'b1;
		@(posedge clock);
		reqReady <= 1'b0;
	endtask
	function automatic dcad_pkg::dcad_req_t mk(input dcad_pkg::dcad_kind_t k,
		input logic [5:0] a1, input logic [5:0] a2, input logic [5:0] c2);
		dcad_pkg::dcad_req_t r;
		r.kind = k;
		r.bank = a2[2:0];
		r.row = {a1[5:2], a2[5:3], 12'h000} & ((19'h00001 << RB) - 19'h00001);
		r.col = {c2, 4'h0};
		r.rowBad = r.row[RB-1] & r.row[RB-2];
		return r;
	endfunction
	task automatic rst_task();
		rst_b <= 1'b0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
	endtask
	// column command to a bank never opened is refused
	task automatic t_closed();
		u_dcad_ctrl_model.send(6'h02, 6'h11, 1'b1);
		repeat (20) @(posedge clock);
		chk_cnt(nNoRow, 1);
	endtask
	// three banks opened, then read, write and mask write sent back to back
	task automatic t_access();
		logic [5:0] a1 [3] = '{6'h3D, 6'h11, 6'h05};
		logic [5:0] a2 [3] = '{6'h2A, 6'h1C, 6'h36};
		logic [5:0] cc [3] = '{6'h3F, 6'h15, 6'h2A};
		logic [2:0] op [3] = '{`DCAD_CMD_RD, `DCAD_CMD_WR, `DCAD_CMD_MWR};
		dcad_pkg::dcad_kind_t kd [3] = '{dcad_pkg::DCAD_KIND_READ, dcad_pkg::DCAD_KIND_WRITE,
			dcad_pkg::DCAD_KIND_MASK_WRITE};
		for (int i = 0; i < 3; i++) u_dcad_ctrl_model.send(a1[i], a2[i], 1'b1);
		for (int i = 0; i < 3; i++) u_dcad_ctrl_model.send({a2[i][2:0], op[i]}, cc[i], 1'b1);
		for (int i = 0; i < 3; i++) chk_req(mk(kd[i], a1[i], a2[i], cc[i]));
	endtask
	// a command with the enable low must leave no trace
	task automatic t_ce();
		u_dcad_ctrl_model.send(6'h12, 6'h01, 1'b0);
		u_dcad_ctrl_model.send(6'h12, 6'h02, 1'b1);
		chk_req(mk(dcad_pkg::DCAD_KIND_READ, 6'h3D, 6'h2A, 6'h02));
	endtask
	// after a second reset: one bank reopened, ten writes while stalled, nine fit
	task automatic t_full();
		u_dcad_ctrl_model.send(6'h09, 6'h3C, 1'b1);
		for (int i = 0; i < 10; i++) u_dcad_ctrl_model.send(6'h24, 6'(i), 1'b1);
		repeat (20) @(posedge clock);
		chk_cnt(nDrop, 1);
		for (int i = 0; i < 9; i++) chk_req(mk(dcad_pkg::DCAD_KIND_WRITE, 6'h09, 6'h3C, 6'(i)));
		chk_cnt(nNoRow, 1);
	endtask
	initial begin
		rst_task();
		t_closed();
		t_access();
		t_ce();
		rst_task();
		t_full();
		report_and_stop();
	end
endmodule
